// ---- include/spi_slave_serial_port_defines.svh ----
// Constants for the slave-mode serial port: encodings, fixed bytes, field positions
`ifndef SPI_SLAVE_SERIAL_PORT_DEFINES_SVH
`define SPI_SLAVE_SERIAL_PORT_DEFINES_SVH
// Overview of operation
// - Slave operation when controller mode is 2 and master select bit cleared.
// - Serial clock comes from the external master, at most 5 Mbps.
// - Frames follow polarity, phase and bit order; order 1 means LSB first.
// - Polarity 1 to 0 without mode 0 reinit sends one spurious 0xFE first.
// - While select is asserted, drive MISO and sample MOSI.
// - Select gates the MISO driver and resets the slave shift register.
// - Separate four-byte transmit and receive FIFOs, served by software or DMA.
// - Receive-valid is set while the receive FIFO holds an unread byte.
// - Byte arriving at a full receive FIFO is dropped; overflow bit and event.
// - DMA overrun error shows after receive FIFO drains; cleared by reset or load.
// - Each received byte shifts out a FIFO byte; empty FIFO flags underrun.
// - Underrun sends previous byte or 0xFF, chosen by the repeat bit.
// - Transmit-idle clears at byte start and sets, with event, after a byte that ends with the FIFO empty.
// - Writing into an empty transmit FIFO leaves status and flags unchanged.
// - Transmit-free clears when FIFO full, sets once a byte frees space.
// - Transmit-idle clears after the first bit, sets when all bytes are out.
// - After select and first receive-valid, new data gets one padding byte first.
// - Events on rises of idle, free, receive-valid, and on overrun and underrun.
// - Events when a DMA buffer active bit falls from 1 to 0.
// - Interrupt needs both the local mask and the top-level enable.
`define SPI_MODE_SPI        2'h2
`define SPI_MODE_OFF        2'h0
`define SPI_FIFO_DEPTH      3'h4
`define SPI_BUSY_TOKEN      8'hFF
`define SPI_SPURIOUS_BYTE   8'hFE
`define SPI_IRQ_RX_VALID    0
`define SPI_IRQ_TX_FREE     1
`define SPI_IRQ_TX_IDLE     2
`define SPI_IRQ_RX_OVERRUN  3
`define SPI_IRQ_TX_UNDERRUN 4
`define SPI_IRQ_TX_DMA_A    5
`define SPI_IRQ_TX_DMA_B    6
`define SPI_IRQ_RX_DMA_A    7
`define SPI_IRQ_RX_DMA_B    8
`define SPI_IRQ_COUNT       9
`endif

// ---- include/spi_slave_serial_port_pkg.sv ----
// Types shared by the slave-mode serial port
package spi_slave_serial_port_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [8:0] irq_vec_t;
  typedef enum logic [1:0] {
    SRC_FIFO    = 2'b00,
    SRC_PAD     = 2'b01,
    SRC_SPUR    = 2'b10,
    SRC_UNDER   = 2'b11
  } tx_src_t;
endpackage

// ---- rtl/spi_slave_serial_port.sv ----
// Slave-mode SPI serial port with transmit/receive FIFOs, status and interrupt flags
`timescale 1ns/1ns
`include "spi_slave_serial_port_defines.svh"
module spi_slave_serial_port (
  input  wire logic                                clock,
  input  wire logic                                srst,
  input  wire logic [1:0]                          controller_mode_field,
  input  wire logic                                master_select_bit,
  input  wire logic                                clock_polarity_bit,
  input  wire logic                                clock_phase_bit,
  input  wire logic                                bit_order_bit,
  input  wire logic                                repeat_select_bit,
  input  wire logic                                sclk_in,
  input  wire logic                                slave_select_low,
  input  wire logic                                mosi_in,
  output logic                                     miso_out,
  output logic                                     miso_oe,
  input  wire logic                                tx_push,
  input  wire spi_slave_serial_port_pkg::byte_t    tx_push_data,
  input  wire logic                                rx_pop,
  output spi_slave_serial_port_pkg::byte_t         rx_head_data,
  output logic                                     rx_valid_bit,
  output logic                                     rx_overflow_bit,
  output logic                                     tx_idle_bit,
  output logic                                     tx_free_bit,
  input  wire logic [1:0]                          tx_dma_active_bits,
  input  wire logic [1:0]                          rx_dma_active_bits,
  input  wire logic [1:0]                          dma_channel_reset_bits,
  input  wire logic                                rx_dma_load,
  output logic                                     rx_dma_error,
  input  wire spi_slave_serial_port_pkg::irq_vec_t irq_flag_clear,
  input  wire spi_slave_serial_port_pkg::irq_vec_t irq_mask_reg,
  input  wire logic                                top_irq_enable,
  output spi_slave_serial_port_pkg::irq_vec_t      irq_flag_reg,
  output logic                                     irq_out
);
  import spi_slave_serial_port_pkg::*;

  // Pin synchronisers; stage one feeds only stage two
  logic [2:0] sclk_sync_reg;
  logic [1:0] ssel_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic       ss_active_d_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      sclk_sync_reg   <= 3'h0;
      ssel_sync_reg   <= 2'h3;
      mosi_sync_reg   <= 2'h0;
      ss_active_d_reg <= 1'b0;
    end else begin
      sclk_sync_reg   <= {sclk_sync_reg[1:0], sclk_in};
      ssel_sync_reg   <= {ssel_sync_reg[0], slave_select_low};
      mosi_sync_reg   <= {mosi_sync_reg[0], mosi_in};
      ss_active_d_reg <= ~ssel_sync_reg[1];
    end
  end

  logic slave_en;
  logic ss_active;
  logic ss_fall;
  logic sclk_edge;
  logic leading_edge;
  logic sample_edge;

  assign slave_en     = (controller_mode_field == `SPI_MODE_SPI) & ~master_select_bit;
  assign ss_active    = slave_en & ~ssel_sync_reg[1];
  assign ss_fall      = ss_active & ~ss_active_d_reg;
  assign sclk_edge    = sclk_sync_reg[2] ^ sclk_sync_reg[1];
  // Leading edge leaves the idle level given by polarity
  assign leading_edge = sclk_edge & (sclk_sync_reg[2] == clock_polarity_bit);
  // Phase 0 samples on leading edges, phase 1 on trailing ones
  assign sample_edge  = ss_active & sclk_edge & (leading_edge ^ clock_phase_bit);
  // Bit counter and receive shifter
  logic [2:0] bit_cnt_reg;
  byte_t      rx_shift_reg;
  byte_t      rx_byte;
  logic       first_bit;
  logic       byte_done;

  assign first_bit = sample_edge & (bit_cnt_reg == 3'h0);
  assign byte_done = sample_edge & (bit_cnt_reg == 3'h7);
  assign rx_byte   = bit_order_bit ? {mosi_sync_reg[1], rx_shift_reg[7:1]}
                                   : {rx_shift_reg[6:0], mosi_sync_reg[1]};

  always_ff @(posedge clock) begin
    if (srst || !ss_active) begin
      bit_cnt_reg  <= 3'h0;
      rx_shift_reg <= 8'h00;
    end else if (sample_edge) begin
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      rx_shift_reg <= rx_byte;
    end
  end

  // Transmit FIFO
  byte_t      tx_mem [4];
  logic [1:0] tx_wr_ptr_reg;
  logic [1:0] tx_rd_ptr_reg;
  logic [2:0] tx_count_reg;
  logic       tx_empty;
  logic       tx_full;
  logic       tx_wr;
  logic       tx_rd;
  logic       load_now;
  tx_src_t    load_src;

  assign tx_empty = (tx_count_reg == 3'h0);
  assign tx_full  = (tx_count_reg == `SPI_FIFO_DEPTH);
  assign tx_wr    = tx_push & ~tx_full;
  assign tx_rd    = load_now & (load_src == SRC_FIFO);

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_wr_ptr_reg <= 2'h0;
      tx_rd_ptr_reg <= 2'h0;
      tx_count_reg  <= 3'h0;
    end else begin
      if (tx_wr) begin
        tx_wr_ptr_reg <= tx_wr_ptr_reg + 2'h1;
      end
      if (tx_rd) begin
        tx_rd_ptr_reg <= tx_rd_ptr_reg + 2'h1;
      end
      if (tx_wr && !tx_rd) begin
        tx_count_reg <= tx_count_reg + 3'h1;
      end else if (tx_rd && !tx_wr) begin
        tx_count_reg <= tx_count_reg - 3'h1;
      end
    end
  end

  // Receive FIFO
  byte_t      rx_mem [4];
  logic [1:0] rx_wr_ptr_reg;
  logic [1:0] rx_rd_ptr_reg;
  logic [2:0] rx_count_reg;
  logic       rx_full;
  logic       rx_wr;
  logic       rx_rd;
  logic       rx_overrun;

  assign rx_full    = (rx_count_reg == `SPI_FIFO_DEPTH);
  assign rx_wr      = byte_done & ~rx_full;
  assign rx_overrun = byte_done & rx_full;
  assign rx_rd      = rx_pop & (rx_count_reg != 3'h0);
  genvar e;
  generate
    for (e = 0; e < 4; e++) begin : g_entry
      always_ff @(posedge clock) begin
        if (srst) begin
          tx_mem[e] <= 8'h00;
          rx_mem[e] <= 8'h00;
        end else begin
          if (tx_wr && tx_wr_ptr_reg == 2'(e)) begin
            tx_mem[e] <= tx_push_data;
          end
          if (rx_wr && rx_wr_ptr_reg == 2'(e)) begin
            rx_mem[e] <= rx_byte;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_wr_ptr_reg <= 2'h0;
      rx_rd_ptr_reg <= 2'h0;
      rx_count_reg  <= 3'h0;
    end else begin
      if (rx_wr) begin
        rx_wr_ptr_reg <= rx_wr_ptr_reg + 2'h1;
      end
      if (rx_rd) begin
        rx_rd_ptr_reg <= rx_rd_ptr_reg + 2'h1;
      end
      if (rx_wr && !rx_rd) begin
        rx_count_reg <= rx_count_reg + 3'h1;
      end else if (rx_rd && !rx_wr) begin
        rx_count_reg <= rx_count_reg - 3'h1;
      end
    end
  end

  // Padding arm, pending pad and spurious-byte tracking
  logic pad_armed_reg;
  logic pad_pending_reg;
  logic spur_pending_reg;
  logic pol_d_reg;

  always_ff @(posedge clock) begin
    if (srst || !ss_active) begin
      pad_armed_reg <= 1'b0;
    end else if (rx_valid_bit) begin
      pad_armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || !ss_active) begin
      pad_pending_reg <= 1'b0;
    end else if (pad_armed_reg && tx_empty && tx_wr && !load_now) begin
      pad_pending_reg <= 1'b1;
    end else if (load_now && load_src == SRC_PAD) begin
      pad_pending_reg <= 1'b0;
    end
  end

  // Only reset, a return to mode 0 or sending the 0xFE clears the stale polarity artefact
  always_ff @(posedge clock) begin
    if (srst) begin
      pol_d_reg        <= 1'b0;
      spur_pending_reg <= 1'b0;
    end else begin
      pol_d_reg <= clock_polarity_bit;
      if (controller_mode_field == `SPI_MODE_OFF) begin
        spur_pending_reg <= 1'b0;
      end else if (pol_d_reg && !clock_polarity_bit) begin
        spur_pending_reg <= 1'b1;
      end else if (load_now && load_src == SRC_SPUR) begin
        spur_pending_reg <= 1'b0;
      end
    end
  end

  // Byte loader: at select assertion and after each finished byte
  byte_t tx_byte_reg;
  byte_t last_tx_reg;
  byte_t pad_byte;
  logic  under_reg;
  assign load_now = ss_fall | byte_done;
  // A byte loaded but never clocked out before deselect does not count as sent
  assign pad_byte = repeat_select_bit ? (byte_done ? tx_byte_reg : last_tx_reg) : `SPI_BUSY_TOKEN;
  always_comb begin
    if (spur_pending_reg) begin
      load_src = SRC_SPUR;
    end else if (pad_pending_reg) begin
      load_src = SRC_PAD;
    end else if (!tx_empty) begin
      load_src = SRC_FIFO;
    end else begin
      load_src = SRC_UNDER;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_byte_reg <= 8'h00;
      last_tx_reg <= 8'h00;
      under_reg   <= 1'b0;
    end else if (load_now) begin
      last_tx_reg <= byte_done ? tx_byte_reg : last_tx_reg;
      case (load_src)
        SRC_SPUR: begin
          tx_byte_reg <= `SPI_SPURIOUS_BYTE;
          under_reg   <= 1'b0;
        end
        SRC_FIFO: begin
          tx_byte_reg <= tx_mem[tx_rd_ptr_reg];
          under_reg   <= 1'b0;
        end
        SRC_PAD, SRC_UNDER: begin
          tx_byte_reg <= pad_byte;
          under_reg   <= 1'b1;
        end
        default: begin
          tx_byte_reg <= `SPI_BUSY_TOKEN;
          under_reg   <= 1'b1;
        end
      endcase
    end
  end

  // Pin drive; bit index follows the counter and the bit order
  logic [2:0] out_idx;
  assign out_idx = bit_order_bit ? bit_cnt_reg : 3'h7 - bit_cnt_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      miso_out <= ss_active ? tx_byte_reg[out_idx] : 1'b0;
      miso_oe  <= ss_active;
    end
  end

  // Status bits
  logic tx_idle_next;
  logic tx_free_next;
  logic rx_valid_next;

  // A write alone never clears idle, so status stays put on a push that does not fill the FIFO
  assign tx_idle_next  = first_bit ? 1'b0 : (byte_done ? tx_empty : tx_idle_bit);
  assign tx_free_next  = (tx_count_reg != `SPI_FIFO_DEPTH);
  assign rx_valid_next = (rx_count_reg != 3'h0);

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_idle_bit  <= 1'b1;
      tx_free_bit  <= 1'b1;
      rx_valid_bit <= 1'b0;
      rx_head_data <= 8'h00;
    end else begin
      tx_idle_bit  <= tx_idle_next;
      tx_free_bit  <= tx_free_next;
      rx_valid_bit <= rx_valid_next;
      rx_head_data <= rx_mem[rx_rd_ptr_reg];
    end
  end

  always_ff @(posedge clock) begin
    if (srst || !slave_en) begin
      rx_overflow_bit <= 1'b0;
    end else if (rx_overrun) begin
      rx_overflow_bit <= 1'b1;
    end
  end

  // DMA view of the overrun waits for the FIFO to drain
  logic rx_err_pending_reg;

  always_ff @(posedge clock) begin
    if (srst || dma_channel_reset_bits[1] || rx_dma_load) begin
      rx_err_pending_reg <= 1'b0;
      rx_dma_error       <= 1'b0;
    end else begin
      if (rx_overrun) begin
        rx_err_pending_reg <= 1'b1;
      end
      if (rx_err_pending_reg && rx_count_reg == 3'h0) begin
        rx_dma_error <= 1'b1;
      end
    end
  end

  // Event capture; a new event beats a simultaneous clear
  logic [1:0] tx_act_d_reg;
  logic [1:0] rx_act_d_reg;
  irq_vec_t   irq_event;
  always_comb begin
    irq_event = '0;
    irq_event[`SPI_IRQ_RX_VALID]    = rx_valid_next & ~rx_valid_bit;
    irq_event[`SPI_IRQ_TX_FREE]     = tx_free_next & ~tx_free_bit;
    irq_event[`SPI_IRQ_TX_IDLE]     = tx_idle_next & ~tx_idle_bit;
    irq_event[`SPI_IRQ_RX_OVERRUN]  = rx_overrun;
    irq_event[`SPI_IRQ_TX_UNDERRUN] = first_bit & under_reg;
    irq_event[`SPI_IRQ_TX_DMA_A]    = tx_act_d_reg[0] & ~tx_dma_active_bits[0];
    irq_event[`SPI_IRQ_TX_DMA_B]    = tx_act_d_reg[1] & ~tx_dma_active_bits[1];
    irq_event[`SPI_IRQ_RX_DMA_A]    = rx_act_d_reg[0] & ~rx_dma_active_bits[0];
    irq_event[`SPI_IRQ_RX_DMA_B]    = rx_act_d_reg[1] & ~rx_dma_active_bits[1];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_flag_reg <= '0;
      irq_out      <= 1'b0;
      tx_act_d_reg <= 2'h0;
      rx_act_d_reg <= 2'h0;
    end else begin
      irq_flag_reg <= (irq_flag_reg & ~irq_flag_clear) | irq_event;
      irq_out      <= top_irq_enable & |(irq_flag_reg & irq_mask_reg);
      tx_act_d_reg <= tx_dma_active_bits;
      rx_act_d_reg <= rx_dma_active_bits;
    end
  end

endmodule // spi_slave_serial_port

// ---- verification/spi_master_model.sv ----
// Behavioural SPI master that clocks the slave port
`timescale 1ns/1ns
module spi_master_model #(
  parameter int HALF = 100
) (
  input  wire logic miso,
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic order,
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi
);
  logic [7:0] rx_byte;
  event       got;
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b1;
  end
  // Clock stands at idle level outside frames; half period keeps 5 Mbps
  task automatic sel(input logic on);
    if (on) begin
      sclk = cpol;
      #(HALF) ss_n = 1'b0;
      #(HALF);
    end else begin
      #(HALF) ss_n = 1'b1;
      mosi = ~mosi;  // Released line never holds the last bit
      #(HALF);
    end
  endtask
  task automatic xfer(input logic [7:0] tx, input int nb);
    int b;
    for (int i = 0; i < nb; i++) begin
      b = order ? i : 7 - i;
      if (!cpha) mosi = tx[b];
      #(HALF) sclk = ~cpol;
      if (cpha) mosi = tx[b];
      else rx_byte[b] = miso;
      #(HALF) sclk = cpol;
      if (cpha) rx_byte[b] = miso;
    end
    if (nb == 8) -> got;
  endtask
endmodule // spi_master_model

// ---- verification/spi_slave_serial_port_sva.sv ----
// Assertion checker for the slave-mode serial port
`timescale 1ns/1ns
module spi_slave_serial_port_sva (
  input wire logic                                clock,
  input wire logic                                srst,
  input wire logic [1:0]                          controller_mode_field,
  input wire logic                                master_select_bit,
  input wire logic                                slave_select_low,
  input wire logic                                miso_out,
  input wire logic                                miso_oe,
  input wire logic                                tx_push,
  input wire logic                                rx_valid_bit,
  input wire logic                                rx_overflow_bit,
  input wire logic                                tx_idle_bit,
  input wire logic                                tx_free_bit,
  input wire logic [1:0]                          tx_dma_active_bits,
  input wire logic [1:0]                          dma_channel_reset_bits,
  input wire logic                                rx_dma_load,
  input wire logic                                rx_dma_error,
  input wire spi_slave_serial_port_pkg::irq_vec_t irq_mask_reg,
  input wire logic                                top_irq_enable,
  input wire spi_slave_serial_port_pkg::irq_vec_t irq_flag_reg,
  input wire logic                                irq_out
);
  import spi_slave_serial_port_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_irq_gate;
    1'b1 |=> irq_out == $past(top_irq_enable && |(irq_flag_reg & irq_mask_reg));
  endproperty
  property p_desel_off;
    slave_select_low [*6] |-> !miso_oe && !miso_out;
  endproperty
  property p_mode_off;
    (controller_mode_field != 2'h2 || master_select_bit) [*6] |-> !miso_oe;
  endproperty
  property p_rxv_evt;
    $rose(rx_valid_bit) |-> ##[0:2] irq_flag_reg[0];
  endproperty
  property p_free_evt;
    $rose(tx_free_bit) |-> ##[0:2] irq_flag_reg[1];
  endproperty
  property p_idle_evt;
    $rose(tx_idle_bit) |-> ##[0:2] irq_flag_reg[2];
  endproperty
  property p_ovf_evt;
    $rose(rx_overflow_bit) |-> ##[0:2] irq_flag_reg[3];
  endproperty
  property p_ovf_hold;
    rx_overflow_bit && controller_mode_field == 2'h2 && !master_select_bit |=> rx_overflow_bit;
  endproperty
  property p_dma_evt;
    $fell(tx_dma_active_bits[0]) |-> ##[0:2] irq_flag_reg[5];
  endproperty
  property p_dma_clr;
    dma_channel_reset_bits[1] |=> !rx_dma_error;
  endproperty
  property p_dma_load;
    rx_dma_load |=> !rx_dma_error;
  endproperty
  property p_push_quiet;
    tx_push && tx_idle_bit && slave_select_low |=> tx_idle_bit [*3];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq output wrong");
  a_desel_off: assert property (p_desel_off) else $error("miso driven");
  a_mode_off: assert property (p_mode_off) else $error("miso on off mode");
  a_rxv_evt: assert property (p_rxv_evt) else $error("no rx event");
  a_free_evt: assert property (p_free_evt) else $error("no free event");
  a_idle_evt: assert property (p_idle_evt) else $error("no idle event");
  a_ovf_evt: assert property (p_ovf_evt) else $error("no overrun event");
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");
  a_dma_evt: assert property (p_dma_evt) else $error("no dma event");
  a_dma_clr: assert property (p_dma_clr) else $error("dma error kept");
  a_push_quiet: assert property (p_push_quiet) else $error("idle moved");
  a_dma_load: assert property (p_dma_load) else $error("dma error kept after load");
  c_ovf: cover property ($rose(rx_overflow_bit));
  c_irq: cover property ($rose(irq_out));
  c_busy: cover property ($fell(tx_idle_bit));
endmodule // spi_slave_serial_port_sva
bind spi_slave_serial_port spi_slave_serial_port_sva chk (.clock, .srst, .controller_mode_field,
  .master_select_bit, .slave_select_low, .miso_out, .miso_oe, .tx_push, .rx_valid_bit,
  .rx_overflow_bit, .tx_idle_bit, .tx_free_bit, .tx_dma_active_bits, .dma_channel_reset_bits,
  .rx_dma_load, .rx_dma_error, .irq_mask_reg, .top_irq_enable, .irq_flag_reg, .irq_out);

// ---- verification/tb_top.sv ----
// Self-checking bench for the slave-mode serial port
`timescale 1ns/1ns
module tb_top;
  import spi_slave_serial_port_pkg::*;
  logic       clock, srst, master_select_bit, clock_polarity_bit, clock_phase_bit;
  logic       bit_order_bit, repeat_select_bit, tx_push, rx_pop, top_irq_enable, rx_dma_load;
  logic       sclk_in, slave_select_low, mosi_in, miso_out, miso_oe, irq_out;
  logic       rx_valid_bit, rx_overflow_bit, tx_idle_bit, tx_free_bit, rx_dma_error;
  logic [1:0] controller_mode_field, dma_channel_reset_bits;
  logic [1:0] tx_dma_active_bits, rx_dma_active_bits;
  byte_t      tx_push_data, rx_head_data, last, q_miso[$], q_mosi[$];
  irq_vec_t   irq_flag_clear, irq_mask_reg, irq_flag_reg;
  int         n_errors = 0, samples_checked = 0;
  wire        miso_w = miso_oe ? miso_out : 1'bz;
  spi_slave_serial_port uut (.clock, .srst, .controller_mode_field, .master_select_bit,
    .clock_polarity_bit, .clock_phase_bit, .bit_order_bit, .repeat_select_bit, .sclk_in,
    .slave_select_low, .mosi_in, .miso_out, .miso_oe, .tx_push, .tx_push_data, .rx_pop,
    .rx_head_data, .rx_valid_bit, .rx_overflow_bit, .tx_idle_bit, .tx_free_bit,
    .tx_dma_active_bits, .rx_dma_active_bits, .dma_channel_reset_bits, .rx_dma_load,
    .rx_dma_error, .irq_flag_clear, .irq_mask_reg, .top_irq_enable, .irq_flag_reg, .irq_out);
  spi_master_model mst (.miso(miso_w), .cpol(clock_polarity_bit), .cpha(clock_phase_bit),
    .order(bit_order_bit), .sclk(sclk_in), .ss_n(slave_select_low), .mosi(mosi_in));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("TB: %0d compared, %0d mismatched", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic push(input byte_t d);
    @(posedge clock);
    tx_push      <= 1'b1;
    tx_push_data <= d;
    @(posedge clock);
    tx_push <= 1'b0;
    tick(2);
  endtask
  task automatic pop();
    @(posedge clock);
    rx_pop <= 1'b1;
    @(posedge clock);
    rx_pop <= 1'b0;
    tick(3);
  endtask
  task automatic clr(input irq_vec_t m);
    @(posedge clock);
    irq_flag_clear <= m;
    @(posedge clock);
    irq_flag_clear <= '0;
  endtask
  // One byte each way; exp is what the slave must send
  task automatic xb(input byte_t exp, input bit keep);
    byte_t m;
    m = $urandom;
    q_miso.push_back(exp);
    if (keep) q_mosi.push_back(m);
    last = exp;
    mst.xfer(m, 8);
  endtask
  always @(mst.got) cmp(mst.rx_byte, q_miso.pop_front(), "slave byte");
  always @(posedge clock) if (rx_pop && rx_valid_bit) cmp(rx_head_data, q_mosi.pop_front(), "rx byte");
  initial begin
    // More than five times the expected run of about 72 us
    #400000;
    n_errors++;
    $display("CHECK FAILED at %0t: run hung", $time);
    end_of_test();
  end
  initial begin
    byte_t d[4];
    srst <= 1'b1;
    {master_select_bit, clock_polarity_bit, clock_phase_bit, bit_order_bit} <= 4'h0;
    {repeat_select_bit, tx_push, rx_pop, top_irq_enable, rx_dma_load} <= 5'h00;
    controller_mode_field <= 2'h2;
    {dma_channel_reset_bits, tx_dma_active_bits, rx_dma_active_bits} <= 6'h00;
    tx_push_data   <= 8'h00;
    irq_flag_clear <= '0;
    irq_mask_reg   <= '0;
    void'($urandom(88));
    tick(5);
    srst <= 1'b0;
    tick(3);
    for (int k = 0; k < 8; k++) begin
      clock_polarity_bit <= k[2];
      clock_phase_bit    <= k[1];
      bit_order_bit      <= k[0];
      tick(2);
      d[0] = $urandom;
      d[1] = $urandom;
      push(d[0]);
      push(d[1]);
      mst.sel(1);
      xb(d[0], 1);
      xb(d[1], 1);
      mst.sel(0);
      pop();
      pop();
      cmp(tx_idle_bit, 1, "idle after frame");
      $display("TB: format %0d done", k);
    end
    clock_polarity_bit <= 1'b0;
    clock_phase_bit    <= 1'b0;
    bit_order_bit      <= 1'b0;
    push(d[0]);
    mst.sel(1);
    xb(8'hFE, 1);
    xb(d[0], 1);
    mst.sel(0);
    pop();
    pop();
    clock_polarity_bit <= 1'b1;
    tick(2);
    clock_polarity_bit    <= 1'b0;
    controller_mode_field <= 2'h0;
    tick(2);
    controller_mode_field <= 2'h2;
    push(d[1]);
    mst.sel(1);
    xb(d[1], 1);
    mst.sel(0);
    pop();
    $display("TB: spurious byte done");
    for (int r = 1; r >= 0; r--) begin
      repeat_select_bit <= r[0];
      clr('1);
      mst.sel(1);
      for (int i = 0; i < 5; i++) xb(r[0] ? last : 8'hFF, i < 4);
      mst.sel(0);
      tick(3);
      cmp(irq_flag_reg[4:2], 3'b111, "underrun idle overrun flags");
      cmp(rx_overflow_bit, 1, "overflow");
      repeat (4) pop();
      cmp(rx_dma_error, 1, "dma error after drain");
      if (r[0]) dma_channel_reset_bits <= 2'b10;
      else rx_dma_load <= 1'b1;
      tick(1);
      dma_channel_reset_bits <= 2'b00;
      rx_dma_load            <= 1'b0;
      controller_mode_field  <= 2'h0;
      tick(2);
      cmp(rx_dma_error, 0, "dma error cleared");
      controller_mode_field <= 2'h2;
      $display("TB: underrun pass %0d done", r);
    end
    mst.sel(1);
    xb(8'hFF, 1);
    tick(5);
    push(d[2]);
    xb(8'hFF, 1);
    xb(8'hFF, 1);
    xb(d[2], 1);
    mst.sel(0);
    repeat (4) pop();
    clr('1);
    for (int i = 0; i < 4; i++) begin
      d[i] = $urandom;
      push(d[i]);
      if (i == 0) cmp(irq_flag_reg, 0, "flags after first push");
    end
    push(8'h5A);
    cmp(tx_free_bit, 0, "free while full");
    mst.sel(1);
    for (int i = 0; i < 4; i++) xb(d[i], 1);
    mst.sel(0);
    repeat (4) pop();
    cmp({tx_free_bit, irq_flag_reg[1]}, 2'b11, "free again");
    $display("TB: fifo done");
    tx_dma_active_bits <= 2'b11;
    rx_dma_active_bits <= 2'b11;
    tick(2);
    tx_dma_active_bits <= 2'b00;
    rx_dma_active_bits <= 2'b00;
    irq_mask_reg       <= 9'h1E0;
    tick(3);
    cmp(irq_flag_reg[8:5], 4'hF, "dma events");
    cmp(irq_out, 0, "top enable off");
    top_irq_enable <= 1'b1;
    tick(3);
    cmp(irq_out, 1, "both enabled");
    clr(9'h1E0);
    tick(3);
    cmp(irq_out, 0, "flags cleared");
    $display("TB: events done");
    mst.sel(1);
    mst.xfer(8'hA5, 3);
    mst.sel(0);
    tick(1);
    master_select_bit <= 1'b1;
    mst.sel(1);
    mst.xfer(8'h3C, 7);
    mst.sel(0);
    tick(1);
    cmp(rx_valid_bit, 0, "nothing received off mode");
    master_select_bit <= 1'b0;
    mst.sel(1);
    xb(8'hFF, 1);
    mst.sel(0);
    pop();
    cmp(9'(q_miso.size()), 9'h000, "slave bytes never seen");
    cmp(9'(q_mosi.size()), 9'h000, "rx bytes never read");
    $display("TB: abort done");
    end_of_test();
  end
endmodule // tb_top
